//--- pmbc_pkg.sv
// Overview of operation
// - Full code word from the code bus is captured on every rising clock edge.
// - Integer loads take whole 32-bit words; stores may write bytes or halfwords.
// - Integer data accesses are 32 bits; only float ops move a double word.
// - A five-bit action code describes the executing instruction each cycle.
// - Action codes 10000 to 11110 select external registers 0 to 14.
// - Data not-ready cancels the current and the following instruction.
// - The aborted instruction re-executes in the same cycle that data not-ready releases.
// - Code not-ready discards the fetching word and retries the same fetch.
// - Interrupt wins over code not-ready; stalled fetch repeats after return.
// - Each address and data bus has an active-low asynchronous drive enable.
// - Four active-low byte write strobes are driven on each store.
// - Pipeline cancel is driven on branches, interrupt returns and interrupts.
// - Interrupt lines are levels sampled on rising edges; data not-ready cancels.
// - The fourth interrupt line serves as the float exception interrupt.
// - An output stays high while the processor is privileged.
// - Reset branches to 0, sets stack pointer to 31 and privileged mode.
// - Input and output move one 32-bit word per cycle over the address bus.
// - An interrupt is taken only with master and line enables both set.
package pmbc_pkg;
   localparam int ADDR_W = 32;
   localparam int WORD_W = 32;
   localparam int IRQ_N = 4;
   localparam int FLOAT_IRQ_IDX = 3;
   localparam logic [31:0] RESET_PC = 32'h0000_0000;
   localparam logic [4:0] STACK_PTR_RESET = 5'h1f;
   localparam logic [31:0] VECTOR_BASE = 32'h0000_0010;
   localparam int VECTOR_SHIFT = 2;
   localparam logic [3:0] XREG_MAX = 4'he;

   typedef enum logic [4:0] {
      PMBC_ACT_IDLE = 5'b00000,
      PMBC_ACT_ADDR = 5'b00001,
      PMBC_ACT_LOAD = 5'b00010,
      PMBC_ACT_STORE = 5'b00011,
      PMBC_ACT_IACK = 5'b00100,
      PMBC_ACT_RFI = 5'b00101,
      PMBC_ACT_WLOAD = 5'b00110,
      PMBC_ACT_WSTORE = 5'b00111,
      PMBC_ACT_XREG = 5'b10000
   } pmbc_action_t;

   typedef enum logic [2:0] {
      PMBC_OP_NONE = 3'b000,
      PMBC_OP_LOAD = 3'b001,
      PMBC_OP_STORE = 3'b010,
      PMBC_OP_XIN = 3'b011,
      PMBC_OP_XOUT = 3'b100,
      PMBC_OP_ADDR = 3'b101
   } pmbc_op_t;

   typedef enum logic [1:0] {
      PMBC_SZ_BYTE = 2'b00,
      PMBC_SZ_HALF = 2'b01,
      PMBC_SZ_WORD = 2'b10
   } pmbc_size_t;
endpackage : pmbc_pkg

//--- pmbc_irq_gate.sv
`timescale 1ns/1ps
module pmbc_irq_gate
   import pmbc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic irq_n_in,
   input wire logic line_en_in,
   input wire logic master_en_in,
   input wire logic taken_in,
   output logic flag_out,
   output logic request_out
);
   logic flag_reg;
   logic flag_next;

   // Level seen at this edge sets the flag; it wins over the acknowledge clear
   assign flag_next = !irq_n_in || (flag_reg && !taken_in);
   // Enables are judged in the same cycle the line is low
   assign request_out = !irq_n_in && line_en_in && master_en_in;
   assign flag_out = flag_reg;

   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end
endmodule : pmbc_irq_gate

//--- pmbc_lane_strobe.sv
`timescale 1ns/1ps
module pmbc_lane_strobe
   import pmbc_pkg::*;
(
   input wire pmbc_size_t size_in,
   input wire logic [1:0] byte_addr_in,
   input wire logic active_in,
   output logic [3:0] strobe_n_out
);
   logic [3:0] lane_mask;

   // Halfwords use the lane pair named by bit 1; words use all lanes
   assign lane_mask = (size_in == PMBC_SZ_BYTE) ? (4'h1 << byte_addr_in) :
                      (size_in == PMBC_SZ_HALF) ? (byte_addr_in[1] ? 4'hc : 4'h3) :
                      4'hf;
   assign strobe_n_out = active_in ? ~lane_mask : 4'hf;
endmodule : pmbc_lane_strobe

//--- pmbc_bus_control.sv
`timescale 1ns/1ps
module pmbc_bus_control
   import pmbc_pkg::*;
#(
   parameter int CODE_W = 64,
   parameter int DATA_W = 64,
   parameter bit HAS_FLOAT = 1'b1
) (
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   // Code side
   output logic [ADDR_W-1:0] code_pointer_bus_out,
   output logic code_pointer_bus_oe_out,
   input wire logic code_pointer_drive_en_n_in,
   input wire logic [CODE_W-1:0] code_bus_in,
   input wire logic code_stall_n_in,
   // Data side
   output logic [ADDR_W-1:0] data_location_bus_out,
   output logic data_location_bus_oe_out,
   input wire logic [ADDR_W-1:0] data_location_bus_in,
   input wire logic data_location_drive_en_n_in,
   output logic [DATA_W-1:0] data_bus_out,
   output logic data_bus_oe_out,
   input wire logic [DATA_W-1:0] data_bus_in,
   input wire logic data_bus_drive_en_n_in,
   output logic [3:0] byte_write_strobes_n_out,
   output logic [4:0] cycle_action_bus_out,
   input wire logic data_abort_n_in,
   // Shared cancel line, open drain
   output logic pipe_cancel_n_out,
   output logic pipe_cancel_oe_out,
   input wire logic pipe_cancel_n_in,
   // Interrupts
   input wire logic irq_line_one_n,
   input wire logic irq_line_two_n,
   input wire logic irq_line_three_n,
   input wire logic irq_line_four_n,
   input wire logic master_irq_en_in,
   input wire logic [IRQ_N-1:0] irq_line_en_in,
   output logic [IRQ_N-1:0] irq_flags_out,
   output logic privileged_mode_flag_out,
   output logic [4:0] stack_ptr_out,
   // Core side
   output logic [CODE_W-1:0] instr_word_out,
   output logic [ADDR_W-1:0] instr_addr_out,
   output logic instr_valid_out,
   input wire logic branch_req_in,
   input wire logic [ADDR_W-1:0] branch_target_in,
   input wire logic rfi_req_in,
   input wire logic op_valid_in,
   output logic op_ready_out,
   input wire pmbc_op_t op_kind_in,
   input wire pmbc_size_t op_size_in,
   input wire logic op_wide_in,
   input wire logic [ADDR_W-1:0] op_addr_in,
   input wire logic [DATA_W-1:0] op_wdata_in,
   input wire logic [3:0] op_xreg_in,
   output logic [DATA_W-1:0] load_data_out,
   output logic load_valid_out
);
   logic [ADDR_W-1:0] pc_reg;
   logic [ADDR_W-1:0] pc_next;
   logic [ADDR_W-1:0] fetch_addr_reg;
   logic [CODE_W-1:0] instr_reg;
   logic instr_valid_reg;
   logic [ADDR_W-1:0] saved_pc_reg;
   logic saved_priv_reg;
   logic priv_reg;
   logic [4:0] sp_reg;
   logic cancel_reg;
   pmbc_op_t exe_kind_reg;
   pmbc_size_t exe_size_reg;
   logic exe_wide_reg;
   logic [ADDR_W-1:0] exe_addr_reg;
   logic [DATA_W-1:0] exe_wdata_reg;
   logic [3:0] exe_xreg_reg;
   logic [DATA_W-1:0] load_data_reg;
   logic load_valid_reg;
   logic iack_reg;
   logic rfi_reg;

   logic stall;
   logic abort;
   logic shared_cancel;
   logic [IRQ_N-1:0] irq_n_lines;
   logic [IRQ_N-1:0] irq_req;
   logic [IRQ_N-1:0] irq_sel;
   logic irq_take;
   logic [1:0] irq_idx;
   logic [ADDR_W-1:0] vector_addr;
   logic exe_load;
   logic exe_store;
   logic exe_xin;
   logic exe_xout;
   logic exe_float_wide;
   logic op_accept;
   logic drive_addr;
   logic drive_data;
   logic [4:0] action_code;
   logic [3:0] strobe_n;

   // Not-ready and cancel are shared wired lines; every chip sees one level
   assign stall = !code_stall_n_in;
   assign abort = !data_abort_n_in;
   assign shared_cancel = !pipe_cancel_n_in;

   assign irq_n_lines = {irq_line_four_n, irq_line_three_n, irq_line_two_n, irq_line_one_n};

   // The fourth line carries float exceptions only when a float unit exists
   generate
      for (genvar i = 0; i < IRQ_N; i++) begin : g_irq
         logic line_en;
         assign line_en = (i == FLOAT_IRQ_IDX) ? (irq_line_en_in[i] && HAS_FLOAT) :
                          irq_line_en_in[i];
         pmbc_irq_gate u_gate (
            .clk_sys_in(clk_sys_in),
            .reset_n_in(reset_n_in),
            .irq_n_in(irq_n_lines[i]),
            .line_en_in(line_en),
            .master_en_in(master_irq_en_in),
            .taken_in(irq_sel[i]),
            .flag_out(irq_flags_out[i]),
            .request_out(irq_req[i])
         );
      end
   endgenerate

   // Lowest numbered line has priority
   assign irq_idx = irq_req[0] ? 2'd0 : irq_req[1] ? 2'd1 : irq_req[2] ? 2'd2 : 2'd3;
   assign irq_take = |irq_req;
   assign irq_sel = irq_take ? (4'h1 << irq_idx) : 4'h0;
   assign vector_addr = VECTOR_BASE + ({30'h0, irq_idx} << VECTOR_SHIFT);

   assign exe_load = (exe_kind_reg == PMBC_OP_LOAD);
   assign exe_store = (exe_kind_reg == PMBC_OP_STORE);
   assign exe_xin = (exe_kind_reg == PMBC_OP_XIN);
   assign exe_xout = (exe_kind_reg == PMBC_OP_XOUT);
   // Integer side is word wide; only float transfers may use the upper half
   assign exe_float_wide = exe_wide_reg && HAS_FLOAT && (DATA_W > WORD_W);

   // While data not-ready holds, the executing op is frozen for replay
   assign op_ready_out = !abort;
   assign op_accept = op_valid_in && !abort;

   // Interrupt outranks a pending code stall; the stalled address is saved
   assign pc_next = irq_take ? vector_addr :
                    rfi_req_in ? saved_pc_reg :
                    branch_req_in ? branch_target_in :
                    (stall || abort) ? pc_reg :
                    pc_reg + 32'h1;

   // Action code reported for the executing cycle; an aborted cycle reports idle
   assign action_code = abort ? PMBC_ACT_IDLE :
                        iack_reg ? PMBC_ACT_IACK :
                        rfi_reg ? PMBC_ACT_RFI :
                        (exe_xin || exe_xout) ? (PMBC_ACT_XREG | {1'b0, exe_xreg_reg}) :
                        exe_load ? (exe_float_wide ? PMBC_ACT_WLOAD : PMBC_ACT_LOAD) :
                        exe_store ? (exe_float_wide ? PMBC_ACT_WSTORE : PMBC_ACT_STORE) :
                        (exe_kind_reg == PMBC_OP_ADDR) ? PMBC_ACT_ADDR :
                        PMBC_ACT_IDLE;

   pmbc_lane_strobe u_strobe (
      .size_in(exe_size_reg),
      .byte_addr_in(exe_addr_reg[1:0]),
      .active_in(exe_store && !abort),
      .strobe_n_out(strobe_n)
   );

   // Enables are asynchronous so a DMA master can take the buses at once
   assign drive_addr = !exe_xin;
   assign drive_data = exe_store && !abort;
   assign code_pointer_bus_oe_out = !code_pointer_drive_en_n_in;
   assign data_location_bus_oe_out = !data_location_drive_en_n_in && drive_addr;
   assign data_bus_oe_out = !data_bus_drive_en_n_in && drive_data;

   // Addresses leave unlatched by design; data address is a byte address
   assign code_pointer_bus_out = pc_reg;
   assign data_location_bus_out = exe_xout ? exe_wdata_reg[ADDR_W-1:0] : exe_addr_reg;
   assign data_bus_out = exe_float_wide ? exe_wdata_reg :
                         {{(DATA_W-WORD_W){1'b0}}, exe_wdata_reg[WORD_W-1:0]};
   assign byte_write_strobes_n_out = strobe_n;
   assign cycle_action_bus_out = action_code;

   assign pipe_cancel_n_out = 1'b0;
   assign pipe_cancel_oe_out = cancel_reg;
   assign privileged_mode_flag_out = priv_reg;
   assign stack_ptr_out = sp_reg;
   assign instr_word_out = instr_reg;
   assign instr_addr_out = fetch_addr_reg;
   assign instr_valid_out = instr_valid_reg;
   assign load_data_out = load_data_reg;
   assign load_valid_out = load_valid_reg;

   // Sequencer state
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pc_reg <= RESET_PC;
         sp_reg <= STACK_PTR_RESET;
         priv_reg <= 1'b1;
         saved_pc_reg <= RESET_PC;
         saved_priv_reg <= 1'b1;
         cancel_reg <= 1'b0;
         iack_reg <= 1'b0;
         rfi_reg <= 1'b0;
      end else begin
         pc_reg <= pc_next;
         cancel_reg <= irq_take || branch_req_in || rfi_req_in;
         iack_reg <= irq_take;
         rfi_reg <= rfi_req_in && !irq_take;
         if (irq_take) begin
            // Aborted or stalled work is redone after the handler returns
            saved_pc_reg <= (abort || stall) ? fetch_addr_reg : pc_reg;
            saved_priv_reg <= priv_reg;
            priv_reg <= 1'b1;
         end else if (rfi_req_in) begin
            priv_reg <= saved_priv_reg;
         end
      end
   end

   // Fetch stage: whole code word taken on each edge unless discarded
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         instr_reg <= '0;
         fetch_addr_reg <= RESET_PC;
         instr_valid_reg <= 1'b0;
      end else begin
         instr_reg <= code_bus_in;
         if (!abort) begin
            fetch_addr_reg <= pc_reg;
         end
         // A stalled, cancelled or aborted word never executes
         instr_valid_reg <= !stall && !shared_cancel && !abort && !irq_take;
      end
   end

   // Execute stage: held through data not-ready so it repeats on release
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         exe_kind_reg <= PMBC_OP_NONE;
         exe_size_reg <= PMBC_SZ_WORD;
         exe_wide_reg <= 1'b0;
         exe_addr_reg <= '0;
         exe_wdata_reg <= '0;
         exe_xreg_reg <= 4'h0;
      end else if (irq_take && abort) begin
         // The cancelled op waits for the handler's return instead of replaying on release
         exe_kind_reg <= PMBC_OP_NONE;
      end else if (!abort) begin
         exe_kind_reg <= (op_accept && !shared_cancel) ? op_kind_in : PMBC_OP_NONE;
         exe_size_reg <= op_wide_in ? PMBC_SZ_WORD : op_size_in;
         exe_wide_reg <= op_wide_in;
         exe_addr_reg <= op_addr_in;
         exe_wdata_reg <= op_wdata_in;
         exe_xreg_reg <= (op_xreg_in > XREG_MAX) ? XREG_MAX : op_xreg_in;
      end
   end

   // Loads take the whole word; an aborted cycle returns nothing
   always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         load_data_reg <= '0;
         load_valid_reg <= 1'b0;
      end else begin
         load_valid_reg <= (exe_load || exe_xin) && !abort;
         if (exe_xin && !abort) begin
            load_data_reg <= {{(DATA_W-ADDR_W){1'b0}}, data_location_bus_in};
         end else if (exe_load && !abort) begin
            load_data_reg <= exe_float_wide ? data_bus_in :
                             {{(DATA_W-WORD_W){1'b0}}, data_bus_in[WORD_W-1:0]};
         end
      end
   end
endmodule : pmbc_bus_control

//--- pmbc_bus_asserts.sv
`timescale 1ns/1ps
module pmbc_bus_asserts
   import pmbc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic reset_n_in,
   input wire logic [ADDR_W-1:0] code_pointer_bus_out,
   input wire logic code_pointer_bus_oe_out,
   input wire logic code_pointer_drive_en_n_in,
   input wire logic data_location_bus_oe_out,
   input wire logic data_location_drive_en_n_in,
   input wire logic data_bus_oe_out,
   input wire logic [3:0] byte_write_strobes_n_out,
   input wire logic [4:0] cycle_action_bus_out,
   input wire logic data_abort_n_in,
   input wire logic code_stall_n_in,
   input wire logic pipe_cancel_oe_out,
   input wire logic branch_req_in,
   input wire logic irq_line_one_n,
   input wire logic [IRQ_N-1:0] irq_flags_out,
   input wire logic privileged_mode_flag_out,
   input wire logic [4:0] stack_ptr_out,
   input wire logic op_ready_out,
   input wire logic load_valid_out
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   sequence s_load;
      cycle_action_bus_out == PMBC_ACT_LOAD;
   endsequence
   // Only a calm cycle is judged; cancels already running may hide a branch
   sequence s_take;
      branch_req_in && data_abort_n_in && code_stall_n_in && !pipe_cancel_oe_out;
   endsequence
   chk_ready_abort: assert property (op_ready_out == data_abort_n_in)
      else $error("op ready differs from data not-ready");
   chk_abort_idle: assert property (!data_abort_n_in |-> cycle_action_bus_out == 5'h00
      && byte_write_strobes_n_out == 4'hf && !data_bus_oe_out)
      else $error("bus activity during data not-ready");
   chk_strobe_store: assert property (byte_write_strobes_n_out != 4'hf
      |-> cycle_action_bus_out inside {PMBC_ACT_STORE, PMBC_ACT_WSTORE})
      else $error("write strobe outside a store");
   chk_code_oe: assert property (code_pointer_bus_oe_out == !code_pointer_drive_en_n_in)
      else $error("code pointer drive wrong");
   chk_loc_oe: assert property (data_location_drive_en_n_in |-> !data_location_bus_oe_out)
      else $error("location bus driven while disabled");
   chk_load_valid: assert property (s_load |=> load_valid_out)
      else $error("load data not delivered");
   chk_cancel_take: assert property (s_take |=> pipe_cancel_oe_out)
      else $error("no cancel after branch");
   chk_irq_sample: assert property (!irq_line_one_n |=> irq_flags_out[0])
      else $error("interrupt flag not set");
   chk_iack_priv: assert property (cycle_action_bus_out == PMBC_ACT_IACK |-> privileged_mode_flag_out)
      else $error("acknowledge without privileged mode");
   chk_xreg_range: assert property (cycle_action_bus_out[4] |-> cycle_action_bus_out != 5'h1f)
      else $error("external register code out of range");
   chk_reset_state: assert property (disable iff (1'b0) !reset_n_in |-> stack_ptr_out == 5'h1f
      && privileged_mode_flag_out && code_pointer_bus_out == RESET_PC)
      else $error("reset state wrong");
endmodule : pmbc_bus_asserts

//--- pmbc_mem_model.sv
`timescale 1ns/1ps
module pmbc_mem_model
   import pmbc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic [31:0] code_addr_in,
   input wire logic [4:0] action_in,
   input wire logic [31:0] loc_in,
   input wire logic [63:0] wdata_in,
   input wire logic [3:0] strobes_n_in,
   input wire logic stall_req_in,
   input wire logic abort_req_in,
   output logic [63:0] code_word_out,
   output logic [63:0] rdata_out,
   output logic stall_n_out,
   output logic abort_n_out
);
   logic [31:0] ram_reg [0:15];
   logic [63:0] hold_reg = 64'h0;
   wire rd = action_in == PMBC_ACT_LOAD;
   // Word carries its own address, so a wrong or stale fetch shows at once
   assign code_word_out = {~code_addr_in, code_addr_in};
   assign stall_n_out = !stall_req_in;
   assign abort_n_out = !abort_req_in;
   // Released bus shows the inverse of the last value, never a kind default
   assign rdata_out = rd ? {32'h0, ram_reg[loc_in[5:2]]} : ~hold_reg;
   always @(posedge clk_sys_in) begin
      if (rd)
         hold_reg <= rdata_out;
      if (abort_n_out) begin
         for (int i = 0; i < 4; i++)
            if (!strobes_n_in[i])
               ram_reg[loc_in[5:2]][8*i +: 8] <= wdata_in[8*i +: 8];
      end
   end
endmodule : pmbc_mem_model

//--- test_processor_memory_bus_control.sv
`timescale 1ns/1ps
module test_processor_memory_bus_control
   import pmbc_pkg::*;
;
   logic clk_sys_in = 1'b0, reset_n_in = 1'b1, stall_req = 1'b0, abort_req = 1'b0;
   logic code_pointer_drive_en_n_in = 1'b0, data_location_drive_en_n_in = 1'b0;
   logic data_bus_drive_en_n_in = 1'b0, branch_req_in = 1'b0, rfi_req_in = 1'b0;
   logic irq_line_one_n = 1'b1, irq_line_two_n = 1'b1, irq_line_three_n = 1'b1;
   logic irq_line_four_n = 1'b1, master_irq_en_in = 1'b0, op_valid_in = 1'b0;
   logic op_wide_in = 1'b0;
   logic [3:0] irq_line_en_in = 4'h0, op_xreg_in = 4'h0;
   logic [31:0] branch_target_in = 32'h0, op_addr_in = 32'h0;
   logic [31:0] data_location_bus_in = 32'h5a5a_a5a5;
   logic [63:0] op_wdata_in = 64'h0;
   pmbc_op_t op_kind_in = PMBC_OP_NONE;
   pmbc_size_t op_size_in = PMBC_SZ_WORD;
   logic [63:0] code_bus_in, data_bus_in, data_bus_out, instr_word_out, load_data_out;
   logic code_stall_n_in, data_abort_n_in, pipe_cancel_n_in, pipe_cancel_n_out;
   logic [31:0] code_pointer_bus_out, data_location_bus_out, instr_addr_out;
   logic code_pointer_bus_oe_out, data_location_bus_oe_out, data_bus_oe_out;
   logic pipe_cancel_oe_out, privileged_mode_flag_out, instr_valid_out;
   logic op_ready_out, load_valid_out;
   logic [3:0] byte_write_strobes_n_out, irq_flags_out;
   logic [4:0] cycle_action_bus_out, stack_ptr_out;
   int miscompares = 0, cmp_count = 0;
   logic muldiv_double_clock = 1'b0;
   int muldiv_edges = 0;
   // Open-drain cancel wire with pull-up
   assign pipe_cancel_n_in = !(pipe_cancel_oe_out && !pipe_cancel_n_out);
   always #5 clk_sys_in = !clk_sys_in;
   // Far-side multiply clock: double rate, an edge on each main clock edge
   always #2.5 muldiv_double_clock = !muldiv_double_clock;
   always @(posedge muldiv_double_clock) muldiv_edges++;
   pmbc_bus_control DUT (.*);
   pmbc_mem_model u_mem (.clk_sys_in(clk_sys_in), .code_addr_in(code_pointer_bus_out),
      .action_in(cycle_action_bus_out), .loc_in(data_location_bus_out),
      .wdata_in(data_bus_out), .strobes_n_in(byte_write_strobes_n_out),
      .stall_req_in(stall_req), .abort_req_in(abort_req), .code_word_out(code_bus_in),
      .rdata_out(data_bus_in), .stall_n_out(code_stall_n_in), .abort_n_out(data_abort_n_in));
   task automatic stop_test;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask : tick
   task automatic done(input string name);
      op_valid_in = 1'b0;
      tick(2);
      $display("%s done", name);
   endtask : done
   // Request held until the edge that takes it; returns inside the execute cycle
   task automatic op(input pmbc_op_t k, input pmbc_size_t s, input logic [31:0] a,
                     input logic [63:0] w, input logic [3:0] x);
      op_kind_in = k;
      op_size_in = s;
      op_addr_in = a;
      op_wdata_in = w;
      op_xreg_in = x;
      op_valid_in = 1'b1;
      while (op_ready_out !== 1'b1 || pipe_cancel_n_in !== 1'b1)
         tick(1);
      tick(1);
   endtask : op
   task automatic t_reset;
      int n;
      reset_n_in = 1'b0;
      tick(2);
      chk("stack pointer", 5'h1f, stack_ptr_out);
      chk("privileged", 1'b1, privileged_mode_flag_out);
      chk("code pointer", 32'h0, code_pointer_bus_out);
      reset_n_in = 1'b1;
      n = muldiv_edges;
      tick(1);
      chk("muldiv rate", 64'h2, muldiv_edges - n);
      $display("reset done");
   endtask : t_reset
   task automatic t_mem;
      int n;
      op(PMBC_OP_STORE, PMBC_SZ_WORD, 32'h24, 64'hcafe_f00d, 4'h0);
      chk("store action", PMBC_ACT_STORE, cycle_action_bus_out);
      chk("word strobes", 4'h0, byte_write_strobes_n_out);
      chk("store addr", 32'h24, data_location_bus_out);
      for (int i = 0; i < 4; i++) begin
         op_valid_in = 1'b0;
         tick(1);
         op(PMBC_OP_STORE, PMBC_SZ_BYTE, 32'h20 + i, {8{8'h10 + 8'(i)}}, 4'h0);
         chk("byte strobes", 4'(~(4'h1 << i)), byte_write_strobes_n_out);
      end
      op(PMBC_OP_LOAD, PMBC_SZ_WORD, 32'h20, 64'h0, 4'h0);
      chk("load action", PMBC_ACT_LOAD, cycle_action_bus_out);
      op_valid_in = 1'b0;
      tick(1);
      chk("load valid", 1'b1, load_valid_out);
      chk("byte merge", 64'h1312_1110, load_data_out);
      op(PMBC_OP_LOAD, PMBC_SZ_WORD, 32'h24, 64'h0, 4'h0);
      op_valid_in = 1'b0;
      abort_req = 1'b1;
      tick(2);
      chk("abort idle", PMBC_ACT_IDLE, cycle_action_bus_out);
      chk("abort ready", 1'b0, op_ready_out);
      abort_req = 1'b0;
      #1;
      for (n = 0; n < 3 && cycle_action_bus_out !== PMBC_ACT_LOAD; n++)
         tick(1);
      chk("reissue", 1'b1, n < 3);
      tick(1);
      chk("reissue data", 64'hcafe_f00d, load_data_out);
      done("memory");
   endtask : t_mem
   task automatic t_xreg;
      logic [3:0] xs [4] = '{4'h0, 4'h3, 4'he, 4'hf};
      foreach (xs[i]) begin
         op(PMBC_OP_XOUT, PMBC_SZ_WORD, 32'h0, 64'h0bad_0000 + xs[i], xs[i]);
         chk("xreg code", 5'h10 + (xs[i] > 4'he ? 4'he : xs[i]), cycle_action_bus_out);
         chk("xout word", 32'h0bad_0000 + xs[i], data_location_bus_out);
      end
      op(PMBC_OP_XIN, PMBC_SZ_WORD, 32'h0, 64'h0, 4'h2);
      chk("xin code", 5'h12, cycle_action_bus_out);
      chk("xin float", 1'b0, data_location_bus_oe_out);
      op_valid_in = 1'b0;
      tick(1);
      chk("xin data", 64'h5a5a_a5a5, load_data_out);
      done("xreg");
   endtask : t_xreg
   task automatic t_fetch;
      logic [31:0] p;
      chk("fetch word", {~instr_addr_out, instr_addr_out}, instr_word_out);
      stall_req = 1'b1;
      tick(1);
      p = code_pointer_bus_out;
      tick(2);
      chk("stall pc", p, code_pointer_bus_out);
      chk("stall valid", 1'b0, instr_valid_out);
      stall_req = 1'b0;
      code_pointer_drive_en_n_in = 1'b1;
      data_location_drive_en_n_in = 1'b1;
      tick(1);
      chk("code oe", 1'b0, code_pointer_bus_oe_out);
      chk("loc oe", 1'b0, data_location_bus_oe_out);
      chk("release valid", 1'b1, instr_valid_out);
      chk("release addr", p, instr_addr_out);
      code_pointer_drive_en_n_in = 1'b0;
      data_location_drive_en_n_in = 1'b0;
      branch_target_in = 32'h40;
      branch_req_in = 1'b1;
      tick(1);
      branch_req_in = 1'b0;
      chk("branch cancel", 1'b1, pipe_cancel_oe_out);
      chk("branch pc", 32'h40, code_pointer_bus_out);
      done("fetch");
   endtask : t_fetch
   task automatic t_irq;
      logic [31:0] p;
      int n;
      irq_line_en_in = 4'h2;
      irq_line_two_n = 1'b0;
      tick(2);
      chk("flag two", 1'b1, irq_flags_out[1]);
      for (n = 0; n < 3; n++) begin
         tick(1);
         chk("masked", 1'b0, cycle_action_bus_out == PMBC_ACT_IACK);
      end
      irq_line_two_n = 1'b1;
      irq_line_en_in = 4'h1;
      master_irq_en_in = 1'b1;
      stall_req = 1'b1;
      tick(1);
      p = code_pointer_bus_out;
      irq_line_one_n = 1'b0;
      tick(1);
      irq_line_one_n = 1'b1;
      for (n = 0; n < 4 && cycle_action_bus_out !== PMBC_ACT_IACK; n++)
         tick(1);
      chk("iack seen", 1'b1, n < 4);
      chk("vector", VECTOR_BASE, code_pointer_bus_out);
      chk("iack priv", 1'b1, privileged_mode_flag_out);
      stall_req = 1'b0;
      tick(2);
      rfi_req_in = 1'b1;
      tick(1);
      rfi_req_in = 1'b0;
      for (n = 0; n < 6 && code_pointer_bus_out !== p; n++)
         tick(1);
      chk("refetch", 1'b1, n < 6);
      done("irq");
   endtask : t_irq
   initial begin
      #20000;
      miscompares++;
      stop_test();
   end
   initial begin
      // Reset falls just after time zero so the asynchronous branch sees an edge
      #1;
      t_reset();
      t_mem();
      t_xreg();
      t_fetch();
      t_irq();
      t_reset();
      stop_test();
   end
endmodule : test_processor_memory_bus_control
bind pmbc_bus_control pmbc_bus_asserts u_chk (.*);
